// *** rtl/refresh_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sdram_sr_defines.svh"
module refresh_engine
  import sdram_sr_pkg::*;
#(
  parameter int TREFI_NS = `SR_TREFI_NS,
  parameter int COLD_STRETCH = `SR_COLD_STRETCH
) (
  input wire logic mclk_i, // system clock
  input wire logic rst_n_i, // synchronised reset, low active
  input wire logic active_i, // in self refresh
  input wire logic hot_i, // high temperature
  input wire logic [7:0] bank_mask_i, // 1 = bank masked
  input wire logic [7:0] seg_mask_i, // 1 = segment masked
  output logic refresh_start_o, // one-cycle pulse
  output logic [63:0] rows_o // regions refreshed, bank*8+segment
);
  localparam int CLK_NS = `SR_CLK_NS;
  // longest interval rounds down so the rate never falls short
  localparam int REFI_RAW = TREFI_NS / CLK_NS;
  localparam int REFI_CYC = (REFI_RAW < 1) ? 1 : REFI_RAW;
  localparam logic [15:0] HOT_LOAD = 16'(REFI_CYC - 1);
  localparam logic [15:0] COLD_LOAD = 16'(REFI_CYC * COLD_STRETCH - 1);

  logic active_q;
  logic [15:0] cnt;

  // internal timer; first refresh fires right after entry
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_q <= 1'b0;
      cnt <= 16'h0000;
      refresh_start_o <= 1'b0;
      rows_o <= 64'h0;
    end else begin
      active_q <= active_i;
      if (!active_i) begin
        cnt <= 16'h0000;
        refresh_start_o <= 1'b0;
      end else if (!active_q || cnt == 16'h0000) begin
        refresh_start_o <= 1'b1;
        rows_o <= region_enable(bank_mask_i, seg_mask_i);
        cnt <= hot_i ? HOT_LOAD : COLD_LOAD;
      end else begin
        refresh_start_o <= 1'b0;
        cnt <= cnt - 16'h0001;
      end
    end
  end

  a_first_refresh: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    active_i && !active_q |=> refresh_start_o)
    else $error("no refresh right after self refresh entry");
  a_mask_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    refresh_start_o |-> (rows_o & ~region_enable($past(bank_mask_i),
    $past(seg_mask_i))) == 64'h0)
    else $error("masked region refreshed");
  a_hot_rate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    active_i && active_q && cnt == 16'h0000 && hot_i
    |=> cnt == HOT_LOAD && refresh_start_o)
    else $error("hot refresh interval wrong");
  c_refresh: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    refresh_start_o && active_q);
endmodule
`default_nettype wire

// *** rtl/sdram_self_refresh_mrr.sv ***
// How it works
// - SRE at rise, CKE fell, CS low, CA=100
// - in self refresh only CKE matters
// - first internal refresh right after entry
// - tXSR counts from first rise after CKE high
// - refresh rate follows temperature
// - bank mask written by MRW, one per bank
// - segment mask, one bit per segment
// - refresh only if bank and segment unmasked
// - MRR at rise, CS low, CA=1000
// - address from CA1:0 fall, CA9:4 rise
// - value on beat0 of DQ7:0 after RL
// - four-beat burst, DQS toggles, not interrupted
// - MRR period two clocks
// - reserved registers return zero, DQS toggles
// - other banks usable during per-bank refresh
// - all-bank refresh zeroes per-bank pointer
// - calibration patterns 1010 and 0011
`timescale 1ns/1ps
`default_nettype none
`include "sdram_sr_defines.svh"
module sdram_self_refresh_mrr
  import sdram_sr_pkg::*;
#(
  parameter int RL = `SR_READ_LATENCY,
  parameter int TXSR_NS = `SR_TXSR_NS,
  parameter int TREFI_NS = `SR_TREFI_NS
) (
  input wire logic mclk_i, // 100 MHz system clock
  input wire logic rst_n_i, // async reset, low active
  input wire logic ck_i, // command clock pin
  input wire logic cke_i, // clock enable pin
  input wire logic cs_n_i, // chip select, low active
  input wire logic [9:0] ca_i, // command/address pins
  input wire logic temp_hot_i, // temperature sensor level
  output var dq_drive_t dq_drive_o, // dq/dqs drive and enables
  output logic self_refresh_o, // in self refresh
  output logic exit_busy_o, // tXSR window running
  output logic refresh_start_o, // internal refresh pulse
  output logic [63:0] refresh_rows_o, // regions of last refresh
  output logic [2:0] pb_bank_o, // per-bank refresh pointer
  output logic [7:0] bank_refresh_mask_o, // bank mask
  output logic [7:0] segment_refresh_mask_o // segment mask
);
  localparam int CLK_NS = `SR_CLK_NS;
  // least time rounds up
  localparam int TXSR_RAW = (TXSR_NS + CLK_NS - 1) / CLK_NS;
  localparam int TXSR_CYC = (TXSR_RAW < 1) ? 1 : TXSR_RAW;
  localparam logic [15:0] TXSR_LOAD = 16'(TXSR_CYC);
  localparam logic [3:0] RL_LAST = 4'(RL - 1);

  // beat value of a mode register read
  function automatic logic [7:0] mr_beat(input logic [7:0] a,
      input logic [1:0] b, input logic [7:0] bm, input logic [7:0] sm);
    logic [3:0] pa;
    logic [3:0] pb;
    pa = `SR_CAL_A_PAT;
    pb = `SR_CAL_B_PAT;
    case (a)
      `SR_MR_BANK: mr_beat = (b == 2'd0) ? bm : 8'h00;
      `SR_MR_SEG: mr_beat = (b == 2'd0) ? sm : 8'h00;
      `SR_MR_CAL_A: mr_beat = {8{pa[b]}};
      `SR_MR_CAL_B: mr_beat = {8{pb[b]}};
      default: mr_beat = 8'h00;
    endcase
  endfunction

  logic [1:0] rst_q;
  logic rst_n;
  ca_bus_t pin_raw;
  ca_bus_t pin_s0;
  ca_bus_t pin_s1;
  logic ck_d;
  logic [1:0] hot_q;
  logic ck_rise;
  logic ck_fall;
  logic cke_prev;
  sr_state_t state;
  logic xsr_run;
  logic [15:0] xsr_cnt;
  logic cmd_ok;
  logic is_sre;
  logic is_mrr;
  logic is_mrw;
  logic is_ref;
  logic cap_pend;
  logic cap_rd;
  logic [5:0] ca_r;
  logic fall_take;
  logic [7:0] fall_addr;
  logic [7:0] rd_addr;
  logic mrr_active;
  logic bursting;
  logic [1:0] beat;
  logic [3:0] lat_cnt;

  // reset release through two flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // pins are asynchronous to mclk; ck is slow enough to sample
  assign pin_raw = '{ck: ck_i, cke: cke_i, cs_n: cs_n_i, ca: ca_i};
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s0 <= '0;
      pin_s1 <= '0;
      ck_d <= 1'b0;
      hot_q <= 2'b00;
    end else begin
      pin_s0 <= pin_raw;
      pin_s1 <= pin_s0;
      ck_d <= pin_s1.ck;
      hot_q <= {hot_q[0], temp_hot_i};
    end
  end
  assign ck_rise = pin_s1.ck & ~ck_d;
  assign ck_fall = ~pin_s1.ck & ck_d;

  // commands only taken when idle and no read burst pending
  assign cmd_ok = ck_rise & (state == ST_IDLE) & ~mrr_active & ~cap_pend;
  assign is_sre = cmd_ok & ~pin_s1.cke & cke_prev & ~pin_s1.cs_n &
                  (pin_s1.ca[2:0] == `SR_CA_SRE);
  assign is_mrr = cmd_ok & pin_s1.cke & ~pin_s1.cs_n &
                  (pin_s1.ca[3:0] == `SR_CA_MRR);
  assign is_mrw = cmd_ok & pin_s1.cke & ~pin_s1.cs_n &
                  (pin_s1.ca[3:0] == `SR_CA_MRW);
  assign is_ref = cmd_ok & pin_s1.cke & ~pin_s1.cs_n &
                  (pin_s1.ca[2:0] == `SR_CA_SRE);

  // cke level seen at the previous rising edge
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cke_prev <= 1'b0;
    end else if (ck_rise) begin
      cke_prev <= pin_s1.cke;
    end
  end

  // self refresh state; in SREF nothing but cke is looked at
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      xsr_run <= 1'b0;
      xsr_cnt <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (is_sre) begin
            state <= ST_SREF;
          end
        end
        ST_SREF: begin
          if (pin_s1.cke) begin
            state <= ST_EXIT;
          end
        end
        ST_EXIT: begin
          if (!xsr_run) begin
            if (ck_rise) begin
              xsr_run <= 1'b1;
              xsr_cnt <= TXSR_LOAD;
            end
          end else if (xsr_cnt == 16'h0001) begin
            xsr_run <= 1'b0;
            state <= ST_IDLE;
          end else begin
            xsr_cnt <= xsr_cnt - 16'h0001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  assign self_refresh_o = (state == ST_SREF);
  assign exit_busy_o = (state == ST_EXIT);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pb_bank_o <= 3'h0;
    end else if (is_ref) begin
      pb_bank_o <= pin_s1.ca[3] ? 3'h0 : pb_bank_o + 3'h1;
    end
  end

  // rise half of address kept until the falling edge
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cap_pend <= 1'b0;
      cap_rd <= 1'b0;
      ca_r <= 6'h00;
    end else if (is_mrr || is_mrw) begin
      cap_pend <= 1'b1;
      cap_rd <= is_mrr;
      ca_r <= pin_s1.ca[9:4];
    end else if (ck_fall) begin
      cap_pend <= 1'b0;
    end
  end
  assign fall_take = cap_pend & ck_fall;
  assign fall_addr = {pin_s1.ca[1:0], ca_r};

  // mask writes; held through self refresh since mrw is blocked
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      bank_refresh_mask_o <= `SR_MASK_RST;
      segment_refresh_mask_o <= `SR_MASK_RST;
    // masks kept, writes only when idle
    end else if (fall_take && !cap_rd) begin
      if (fall_addr == `SR_MR_BANK) begin
        bank_refresh_mask_o <= pin_s1.ca[9:2];
      end
      if (fall_addr == `SR_MR_SEG) begin
        segment_refresh_mask_o <= pin_s1.ca[9:2];
      end
    end
  end

  // read latency, then four beats on consecutive ck edges
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mrr_active <= 1'b0;
      bursting <= 1'b0;
      beat <= 2'd0;
      lat_cnt <= 4'h0;
      rd_addr <= 8'h00;
      dq_drive_o <= '0;
    end else if (is_mrr) begin
      mrr_active <= 1'b1;
      lat_cnt <= 4'h0;
    end else if (mrr_active) begin
      if (fall_take) begin
        rd_addr <= fall_addr;
      end
      if (!bursting && ck_rise) begin
        if (lat_cnt == RL_LAST) begin
          bursting <= 1'b1;
          beat <= 2'd0;
          dq_drive_o <= '{dq: mr_beat(rd_addr, 2'd0, bank_refresh_mask_o,
                          segment_refresh_mask_o),
                          dq_oe: 1'b1, dqs: 1'b1, dqs_oe: 1'b1};
        end else begin
          lat_cnt <= lat_cnt + 4'h1;
        end
      end else if (bursting && (ck_rise || ck_fall)) begin
        if (beat == 2'd3) begin
          bursting <= 1'b0;
          mrr_active <= 1'b0;
          dq_drive_o <= '0;
        end else begin
          beat <= beat + 2'd1;
          dq_drive_o.dq <= mr_beat(rd_addr, beat + 2'd1,
                           bank_refresh_mask_o, segment_refresh_mask_o);
          dq_drive_o.dqs <= ~dq_drive_o.dqs;
        end
      end
    end
  end

  // per-bank refresh never blocks other banks
  refresh_engine #(
    .TREFI_NS(TREFI_NS)
  ) u_refresh (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .active_i(state == ST_SREF),
    .hot_i(hot_q[1]),
    .bank_mask_i(bank_refresh_mask_o),
    .seg_mask_i(segment_refresh_mask_o),
    .refresh_start_o(refresh_start_o),
    .rows_o(refresh_rows_o)
  );

  logic [15:0] xsr_seen;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      xsr_seen <= 16'h0000;
    end else begin
      xsr_seen <= xsr_run ? xsr_seen + 16'h0001 : 16'h0000;
    end
  end

  a_entry_take: assert property (@(posedge mclk_i) disable iff (!rst_n)
    is_sre |=> state == ST_SREF)
    else $error("entry command not taken");
  a_sref_hold: assert property (@(posedge mclk_i) disable iff (!rst_n)
    state == ST_SREF && !pin_s1.cke |=> state == ST_SREF
    && !dq_drive_o.dq_oe)
    else $error("self refresh left without cke");
  a_xsr_length: assert property (@(posedge mclk_i) disable iff (!rst_n)
    $fell(xsr_run) |-> xsr_seen == TXSR_LOAD && state == ST_IDLE)
    else $error("exit window length wrong");
  a_mask_keep: assert property (@(posedge mclk_i) disable iff (!rst_n)
    state != ST_IDLE |=> $stable(bank_refresh_mask_o)
    && $stable(segment_refresh_mask_o))
    else $error("mask changed in self refresh");
  a_mrr_beat0: assert property (@(posedge mclk_i) disable iff (!rst_n)
    $rose(dq_drive_o.dq_oe) |-> dq_drive_o.dq == mr_beat(rd_addr, 2'd0,
    bank_refresh_mask_o, segment_refresh_mask_o) && dq_drive_o.dqs)
    else $error("first read beat wrong");
  a_mrr_noint: assert property (@(posedge mclk_i) disable iff (!rst_n)
    mrr_active |-> !is_mrr && !is_mrw && !is_sre)
    else $error("read burst interrupted");
  a_dqs_toggle: assert property (@(posedge mclk_i) disable iff (!rst_n)
    bursting && beat != 2'd3 && (ck_rise || ck_fall)
    |=> dq_drive_o.dqs != $past(dq_drive_o.dqs) && dq_drive_o.dqs_oe)
    else $error("strobe did not toggle in read burst");
  a_ptr_zero: assert property (@(posedge mclk_i) disable iff (!rst_n)
    is_ref && pin_s1.ca[3] |=> pb_bank_o == 3'h0)
    else $error("all-bank refresh kept pointer");
  a_mrr_start: assert property (@(posedge mclk_i) disable iff (!rst_n)
    is_mrr |=> mrr_active ##[1:1000] dq_drive_o.dqs_oe)
    else $error("read never answered");
  c_sref: cover property (@(posedge mclk_i) disable iff (!rst_n)
    state == ST_SREF ##1 state == ST_EXIT);
  c_exit: cover property (@(posedge mclk_i) disable iff (!rst_n)
    $fell(xsr_run));
  c_burst: cover property (@(posedge mclk_i) disable iff (!rst_n)
    $fell(dq_drive_o.dqs_oe));
endmodule
`default_nettype wire

// *** rtl/sdram_sr_defines.svh ***
`ifndef SDRAM_SR_DEFINES_SVH
`define SDRAM_SR_DEFINES_SVH
// timing, in its own unit
`define SR_CLK_NS 10
`define SR_TXSR_NS 140
`define SR_TREFI_NS 3900
`define SR_COLD_STRETCH 4
`define SR_READ_LATENCY 3
// command codes on ca[2:0] / ca[3:0]
`define SR_CA_SRE 3'h4
`define SR_CA_MRR 4'h8
`define SR_CA_MRW 4'h0
// mode register addresses
`define SR_MR_BANK 8'h10
`define SR_MR_SEG 8'h11
`define SR_MR_CAL_A 8'h20
`define SR_MR_CAL_B 8'h28
// calibration patterns, bit n is beat n
`define SR_CAL_A_PAT 4'h5
`define SR_CAL_B_PAT 4'hC
// mask reset values
`define SR_MASK_RST 8'h00
`endif

// *** rtl/sdram_sr_pkg.sv ***
`default_nettype none
package sdram_sr_pkg;
  // sampled command pins, moved as one group
  typedef struct packed {
    logic ck;
    logic cke;
    logic cs_n;
    logic [9:0] ca;
  } ca_bus_t;
  // drive side of the dq/dqs pins
  typedef struct packed {
    logic [7:0] dq;
    logic dq_oe;
    logic dqs;
    logic dqs_oe;
  } dq_drive_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SREF = 3'b010,
    ST_EXIT = 3'b100
  } sr_state_t;
  // a region is refreshed only when bank and segment are both unmasked
  function automatic logic [63:0] region_enable(input logic [7:0] bm,
                                                input logic [7:0] sm);
    logic [63:0] r;
    r = 64'h0;
    for (int b = 0; b < 8; b++) begin
      for (int s = 0; s < 8; s++) begin
        r[b*8+s] = ~bm[b] & ~sm[s];
      end
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// *** tb/lpddr_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpddr_ctrl_model (
  input wire logic mclk_i, // system clock
  output logic ck_o, // command clock, eight mclk per period
  output logic cke_o, // clock enable
  output logic cs_n_o, // chip select, low active
  output logic [9:0] ca_o // command/address
);
  logic run = 1'b1; // clock runs
  logic pend = 1'b0; // a command waits for the next rise
  logic cke_v = 1'b1; // cke level to present
  logic cs_v;
  logic [9:0] r_v;
  logic [9:0] f_v;
  int ph = 4;

  initial begin
    ck_o = 1'b0;
    cke_o = 1'b1;
    cs_n_o = 1'b1;
    ca_o = 10'h000;
  end

  // clock stop only parks low at phase 4, so no runt pulse escapes
  always @(negedge mclk_i) begin
    if (run || ph != 4) begin
      ph <= (ph + 1) % 8;
      ck_o <= ((ph + 1) % 8) < 4;
      // two mclk of setup, then NOP with moving ca
      if (ph == 5) begin
        cke_o <= cke_v;
        cs_n_o <= pend ? cs_v : 1'b1;
        ca_o <= pend ? r_v : ~ca_o;
      end
      if (ph == 1) begin
        ca_o <= pend ? f_v : ~ca_o;
        pend <= 1'b0;
      end
    end
  end

  // one command, then NOPs until the caller sends again
  task automatic send(input logic c, input logic [9:0] r,
                      input logic [9:0] f);
    do @(negedge mclk_i); while (ph != 2);
    cke_v = c;
    cs_v = 1'b0;
    r_v = r;
    f_v = f;
    pend = 1'b1;
    do @(negedge mclk_i); while (pend);
  endtask
endmodule
`default_nettype wire

// *** tb/sdram_self_refresh_mrr_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdram_self_refresh_mrr_tb_top;
  import sdram_sr_pkg::*;
  localparam int TREFI = 200;
  localparam int HOT_GAP = TREFI / 10;
  localparam int COLD_GAP = HOT_GAP * 4;
  localparam logic [7:0] BM = 8'h82;
  localparam logic [7:0] SM = 8'h84;
  logic mclk;
  logic rst_n;
  logic hot;
  wire logic ck;
  wire logic cke;
  wire logic cs_n;
  wire logic [9:0] ca;
  dq_drive_t dq;
  logic sref;
  logic xbusy;
  logic rstart;
  logic [63:0] rows;
  logic [2:0] pb;
  logic [7:0] bm;
  logic [7:0] sm;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  sdram_self_refresh_mrr #(.TREFI_NS(TREFI)) dut (
    .mclk_i(mclk), .rst_n_i(rst_n), .ck_i(ck), .cke_i(cke), .cs_n_i(cs_n),
    .ca_i(ca), .temp_hot_i(hot), .dq_drive_o(dq), .self_refresh_o(sref),
    .exit_busy_o(xbusy), .refresh_start_o(rstart), .refresh_rows_o(rows),
    .pb_bank_o(pb), .bank_refresh_mask_o(bm), .segment_refresh_mask_o(sm)
  );
  lpddr_ctrl_model ctrl (
    .mclk_i(mclk), .ck_o(ck), .cke_o(cke), .cs_n_o(cs_n), .ca_o(ca)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // hang guard, the whole run needs well under this
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [63:0] seen,
                     input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic clocks(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wait_start(output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (rstart !== 1'b1 && n < 200);
  endtask

  task automatic mrw(input logic [7:0] a, input logic [7:0] d);
    ctrl.send(1'b1, {a[5:0], 4'h0}, {d, a[7:6]});
  endtask

  // beats sampled once per half ck, each beat lasts four mclk
  task automatic mrr(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] got;
    int n;
    n = 0;
    ctrl.send(1'b1, {a[5:0], 4'h8}, {8'h5A, a[7:6]});
    while (dq.dq_oe !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk("mrr latency", 64'(n >= 22 && n <= 26), 64'h1);
    for (int i = 0; i < 4; i++) begin
      got[i*8 +: 8] = dq.dq;
      chk("mrr strobe", 64'({dq.dq_oe, dq.dqs_oe, dq.dqs}),
          {61'h0, 2'b11, ~i[0]});
      clocks(4);
    end
    chk("mrr data", 64'(got), 64'(exp));
    chk("mrr release", 64'({dq.dq_oe, dq.dqs_oe}), 64'h0);
  endtask

  task automatic t_reset();
    chk("reset state", 64'({dq, sref, xbusy, pb, bm, sm}), 64'h0);
    $display("test reset done");
  endtask

  task automatic t_refcmd();
    ctrl.send(1'b1, 10'h004, 10'h000);
    ctrl.send(1'b1, 10'h004, 10'h000);
    clocks(4);
    chk("bank pointer", 64'(pb), 64'h2);
    ctrl.send(1'b1, 10'h00C, 10'h000);
    clocks(4);
    chk("pointer cleared", 64'(pb), 64'h0);
    chk("refresh not sref", 64'(sref), 64'h0);
    $display("test refresh commands done");
  endtask

  task automatic t_regs();
    mrw(8'h10, BM);
    mrw(8'h11, SM);
    mrw(8'h12, 8'h55);
    clocks(8);
    chk("bank mask", 64'(bm), 64'(BM));
    chk("segment mask", 64'(sm), 64'(SM));
    mrr(8'h10, {24'h0, BM});
    mrr(8'h11, {24'h0, SM});
    mrr(8'h20, 32'h00FF00FF);
    mrr(8'h28, 32'hFFFF0000);
    mrr(8'h05, 32'h0);
    $display("test mode registers done");
  endtask

  task automatic t_sref();
    int n;
    int g;
    logic [63:0] er;
    for (int b = 0; b < 8; b++) begin
      for (int s = 0; s < 8; s++) begin
        er[b*8+s] = !(BM[b] | SM[s]);
      end
    end
    // banks are idle here, cke was high at the last rise
    ctrl.send(1'b0, 10'h004, 10'h3FF);
    wait_start(n);
    chk("first refresh", 64'(n < 10), 64'h1);
    chk("sref entry", 64'(sref), 64'h1);
    clocks(1);
    chk("refresh rows", rows, er);
    wait_start(g);
    chk("cold gap", 64'(g >= COLD_GAP - 1 && g <= COLD_GAP + 1), 64'h1);
    hot = 1'b1;
    wait_start(n);
    wait_start(g);
    chk("hot gap", 64'(g >= HOT_GAP - 1 && g <= HOT_GAP + 1), 64'h1);
    // aimed at the bank mask and sent with cke low, so both cke and the state refuse it
    ctrl.send(1'b0, 10'h100, {8'hFF, 2'b00});
    clocks(6);
    chk("write ignored", 64'({bm, sm}), 64'({BM, SM}));
    ctrl.run = 1'b0;
    clocks(40);
    chk("sref clock stop", 64'(sref), 64'h1);
    ctrl.run = 1'b1;
    // long residency, two stable ck before cke rises
    clocks(16);
    ctrl.cke_v = 1'b1;
    n = 0;
    while (xbusy !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk("exit left sref", 64'({xbusy, sref}), 64'h2);
    g = 0;
    // only NOPs and cke high while the exit window runs
    while (xbusy !== 1'b0 && g < 40) begin
      @(negedge mclk);
      g++;
    end
    chk("exit window", 64'(g >= 15 && g <= 17), 64'h1);
    // one all-bank refresh before any later entry
    ctrl.send(1'b1, 10'h00C, 10'h000);
    mrr(8'h10, {24'h0, BM});
    mrr(8'h11, {24'h0, SM});
    $display("test self refresh done");
  endtask

  initial begin
    hot = 1'b0;
    rst_n = 1'b0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    clocks(10);
    t_reset();
    t_refcmd();
    t_regs();
    t_sref();
    conclude();
  end
endmodule
`default_nettype wire
